/* src/adcc_pkg.sv */
// package: constants, register map and carrier types of the converter control
package adcc_pkg;

    // register word indices, byte address is index times four
    localparam logic [2:0] ADCC_IDX_SC       = 3'h0;
    localparam logic [2:0] ADCC_IDX_RES_HI   = 3'h1;
    localparam logic [2:0] ADCC_IDX_RES_LO   = 3'h2;
    localparam logic [2:0] ADCC_IDX_CLK_CFG  = 3'h3;
    localparam logic [2:0] ADCC_IDX_EVT_STAT = 3'h4;
    localparam logic [2:0] ADCC_IDX_EVT_MASK = 3'h5;

    // status/control fields
    localparam int unsigned ADCC_SC_DONE_BIT  = 7;
    localparam int unsigned ADCC_SC_IRQEN_BIT = 6;
    localparam int unsigned ADCC_SC_CONT_BIT  = 5;
    localparam logic [7:0]  ADCC_SC_RESET     = 8'h1F;

    // channel codes
    localparam logic [4:0] ADCC_CH_PIN_LAST = 5'h05;
    localparam logic [4:0] ADCC_CH_BANDGAP  = 5'h1A;
    localparam logic [4:0] ADCC_CH_REF_HIGH = 5'h1D;
    localparam logic [4:0] ADCC_CH_REF_LOW  = 5'h1E;
    localparam logic [4:0] ADCC_CH_OFF      = 5'h1F;

    // converter clock configuration fields
    localparam int unsigned ADCC_CK_LSMP_BIT  = 0;
    localparam int unsigned ADCC_CK_ASYNC_BIT = 1;
    localparam logic [1:0]  ADCC_CK_RESET     = 2'h0;

    // event status / mask bits
    localparam int unsigned ADCC_EVT_W     = 3;
    localparam int unsigned ADCC_EVT_DONE  = 0;
    localparam int unsigned ADCC_EVT_ABORT = 1;
    localparam int unsigned ADCC_EVT_HALT  = 2;
    localparam logic [2:0]  ADCC_EVT_RESET = 3'h0;

    typedef enum logic [1:0] {
        ADCC_ST_IDLE = 2'b00,
        ADCC_ST_CONV = 2'b01,
        ADCC_ST_HALT = 2'b11
    } adcc_state_t;

    typedef struct packed {
        logic       irq_en;
        logic       cont;
        logic [4:0] channel;
    } adcc_ctrl_t;

    typedef struct packed {
        logic       start;
        logic       abort;
        logic       powered;
        logic       isolate;
        logic       long_sample;
        logic [4:0] channel;
    } adcc_conv_cmd_t;

endpackage : adcc_pkg

/* src/adcc_top.sv */
// converter control: register slave, conversion sequencer, interrupts
//
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module adcc_top #(
    parameter int unsigned RES_W = 10
) (
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // avalon-mm slave
    input  wire logic [4:0]             i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [31:0]            i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    output logic      [31:0]            o_avs_readdata,
    output logic                        o_avs_waitrequest,
    // converter core
    input  wire logic                   i_conv_eoc,
    input  wire logic [RES_W-1:0]       i_conv_data,
    output adcc_pkg::adcc_conv_cmd_t    o_conv_cmd,
    // system
    input  wire logic                   i_stop_mode,
    output logic                        o_conv_irq,
    output logic                        o_irq
);

    adcc_pkg::adcc_state_t  state_ff;
    adcc_pkg::adcc_ctrl_t   ctrl_ff;
    logic                   done_ff;
    logic                   irq_pend_ff;
    logic                   cont_run_ff;
    logic                   start_ff;
    logic                   abort_ff;
    logic [RES_W-1:0]       result_ff;
    logic [1:0]             clk_cfg_ff;
    logic [2:0]             evt_ff;
    logic [2:0]             mask_ff;
    logic [2:0]             evt_snap_ff;
    logic                   stop_q_ff;
    logic                   rd_ack_ff;
    logic [31:0]            rdata_ff;

    logic                   sel_sc;
    logic                   sel_hi;
    logic                   sel_lo;
    logic                   sel_ck;
    logic                   sel_es;
    logic                   sel_em;
    logic [31:0]            nxt_rdata;
    logic [2:0]             evt_set;
    logic [2:0]             evt_clr;

    wire logic [2:0] idx      = i_avs_address[4:2];
    wire logic       wr_take  = i_avs_write & ~o_avs_waitrequest;
    wire logic       rd_take  = i_avs_read & rd_ack_ff;
    wire logic       wr_lo    = wr_take & i_avs_byteenable[0];
    wire logic       sc_wr    = wr_lo & sel_sc;
    wire logic       ck_wr    = wr_lo & sel_ck;
    wire logic       em_wr    = wr_lo & sel_em;
    wire logic       lo_rd    = rd_take & sel_lo;
    wire logic       hi_rd    = rd_take & sel_hi;
    wire logic       es_rd    = rd_take & sel_es;
    wire logic [4:0] wr_ch    = i_avs_writedata[4:0];
    wire logic       wr_cont  =
        i_avs_writedata[adcc_pkg::ADCC_SC_CONT_BIT];
    wire logic       wr_run   = wr_ch != adcc_pkg::ADCC_CH_OFF;
    wire logic       async_en =
        clk_cfg_ff[adcc_pkg::ADCC_CK_ASYNC_BIT];
    wire logic       converting = state_ff == adcc_pkg::ADCC_ST_CONV;
    // stop without the async clock kills the converter clock
    wire logic       stop_enter = i_stop_mode & ~stop_q_ff & ~async_en;
    wire logic       eoc_ok   = i_conv_eoc & converting;

    // reads take one wait cycle so read data comes from a flip-flop
    assign o_avs_waitrequest = i_avs_read & ~rd_ack_ff;
    assign o_avs_readdata    = rdata_ff;

    always_comb begin
        sel_sc = 1'b0;
        sel_hi = 1'b0;
        sel_lo = 1'b0;
        sel_ck = 1'b0;
        sel_es = 1'b0;
        sel_em = 1'b0;
        if (idx == adcc_pkg::ADCC_IDX_SC) begin
            sel_sc = 1'b1;
        end else if (idx == adcc_pkg::ADCC_IDX_RES_HI) begin
            sel_hi = 1'b1;
        end else if (idx == adcc_pkg::ADCC_IDX_RES_LO) begin
            sel_lo = 1'b1;
        end else if (idx == adcc_pkg::ADCC_IDX_CLK_CFG) begin
            sel_ck = 1'b1;
        end else if (idx == adcc_pkg::ADCC_IDX_EVT_STAT) begin
            sel_es = 1'b1;
        end else if (idx == adcc_pkg::ADCC_IDX_EVT_MASK) begin
            sel_em = 1'b1;
        end
    end

    // unmapped addresses read as zero, writes there are dropped
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        if (sel_sc) begin
            nxt_rdata[7:0] = {done_ff, ctrl_ff};
        end else if (sel_hi) begin
            nxt_rdata[RES_W-9:0] = result_ff[RES_W-1:8];
        end else if (sel_lo) begin
            nxt_rdata[7:0] = result_ff[7:0];
        end else if (sel_ck) begin
            nxt_rdata[1:0] = clk_cfg_ff;
        end else if (sel_es) begin
            nxt_rdata[2:0] = evt_ff;
        end else if (sel_em) begin
            nxt_rdata[2:0] = mask_ff;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_ack_ff   <= 1'b0;
            rdata_ff    <= 32'h0000_0000;
            evt_snap_ff <= adcc_pkg::ADCC_EVT_RESET;
        end else begin
            rd_ack_ff <= i_avs_read & ~rd_ack_ff;
            if (i_avs_read & ~rd_ack_ff) begin
                rdata_ff    <= nxt_rdata;
                evt_snap_ff <= evt_ff;
            end
        end
    end

    // software-visible control fields
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_ff    <= adcc_pkg::ADCC_SC_RESET[6:0];
            clk_cfg_ff <= adcc_pkg::ADCC_CK_RESET;
            mask_ff    <= adcc_pkg::ADCC_EVT_RESET;
        end else begin
            if (sc_wr) begin
                ctrl_ff <= i_avs_writedata[6:0];
            end
            if (ck_wr) begin
                clk_cfg_ff <= i_avs_writedata[1:0];
            end
            if (em_wr) begin
                mask_ff <= i_avs_writedata[2:0];
            end
        end
    end

    // sequencer; a control write is the only way out of idle and halt
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= adcc_pkg::ADCC_ST_IDLE;
        end else if (sc_wr) begin
            if (wr_run) begin
                state_ff <= adcc_pkg::ADCC_ST_CONV;
            end else begin
                state_ff <= adcc_pkg::ADCC_ST_IDLE;
            end
        end else if (stop_enter && converting) begin
            state_ff <= adcc_pkg::ADCC_ST_HALT;
        end else if (eoc_ok && !cont_run_ff) begin
            state_ff <= adcc_pkg::ADCC_ST_IDLE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cont_run_ff <= 1'b0;
        end else if (sc_wr) begin
            cont_run_ff <= wr_cont & wr_run;
        end else if (ck_wr || stop_enter) begin
            cont_run_ff <= 1'b0;
        end
    end

    // restart follows eoc by one bus cycle; slow bus clocks stretch
    // the gap between samples
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            start_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            start_ff <= (sc_wr & wr_run)
                      | (eoc_ok & cont_run_ff & ~sc_wr
                         & ~ck_wr & ~stop_enter);
            abort_ff <= (sc_wr | stop_enter)
                      & converting & ~eoc_ok;
        end
    end

    // flag and result: a finishing conversion beats a same-cycle clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            done_ff   <= 1'b0;
            result_ff <= '0;
        end else begin
            if (eoc_ok) begin
                result_ff <= i_conv_data;
            end
            if (eoc_ok) begin
                done_ff <= 1'b1;
            end else if (sc_wr || lo_rd) begin
                done_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            irq_pend_ff <= 1'b0;
        end else if (eoc_ok && ctrl_ff.irq_en) begin
            irq_pend_ff <= 1'b1;
        end else if (sc_wr || lo_rd || hi_rd) begin
            irq_pend_ff <= 1'b0;
        end
    end

    // sticky event log; a read clears only the bits it returned
    always_comb begin
        evt_set = 3'h0;
        evt_set[adcc_pkg::ADCC_EVT_DONE]  = eoc_ok;
        evt_set[adcc_pkg::ADCC_EVT_ABORT] = (sc_wr | stop_enter)
                                          & converting & ~eoc_ok;
        evt_set[adcc_pkg::ADCC_EVT_HALT]  = stop_enter & converting;
        evt_clr = es_rd ? evt_snap_ff : 3'h0;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            evt_ff    <= adcc_pkg::ADCC_EVT_RESET;
            stop_q_ff <= 1'b0;
        end else begin
            evt_ff    <= (evt_ff & ~evt_clr) | evt_set;
            stop_q_ff <= i_stop_mode;
        end
    end

    assign o_irq      = |(evt_ff & mask_ff);
    assign o_conv_irq = irq_pend_ff;

    always_comb begin
        o_conv_cmd.start       = start_ff;
        o_conv_cmd.abort       = abort_ff;
        o_conv_cmd.powered     = converting;
        o_conv_cmd.isolate     =
            ctrl_ff.channel == adcc_pkg::ADCC_CH_OFF;
        o_conv_cmd.long_sample =
            clk_cfg_ff[adcc_pkg::ADCC_CK_LSMP_BIT];
        o_conv_cmd.channel     = ctrl_ff.channel;
    end

    a_write_starts:
    assert property (@(posedge i_clk) disable iff (i_rst)
        sc_wr && wr_run |=> start_ff && converting)
        else $error("control write did not start a conversion");

    a_off_no_start:
    assert property (@(posedge i_clk) disable iff (i_rst)
        sc_wr && !wr_run |=> !start_ff && !converting ##1 !start_ff)
        else $error("channel off still converted");

    a_done_on_eoc:
    assert property (@(posedge i_clk) disable iff (i_rst)
        eoc_ok |=> done_ff && result_ff == $past(i_conv_data))
        else $error("end of conversion not captured");

    a_done_clears:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (sc_wr || lo_rd) && !eoc_ok |=> !done_ff)
        else $error("done flag not cleared");

    a_irq_follows:
    assert property (@(posedge i_clk) disable iff (i_rst)
        !o_conv_irq && !(eoc_ok && ctrl_ff.irq_en) |=> !o_conv_irq)
        else $error("conversion request without cause");

    a_irq_raise:
    assert property (@(posedge i_clk) disable iff (i_rst)
        eoc_ok && ctrl_ff.irq_en |=> o_conv_irq && done_ff)
        else $error("conversion request missing");

    a_irq_withdraw:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (sc_wr || lo_rd || hi_rd) && !eoc_ok |=> !o_conv_irq)
        else $error("conversion request not withdrawn");

    a_cont_restart:
    assert property (@(posedge i_clk) disable iff (i_rst)
        eoc_ok && cont_run_ff && !sc_wr && !ck_wr && !stop_enter
        |=> start_ff && converting)
        else $error("continuous mode did not restart");

    a_cont_stops:
    assert property (@(posedge i_clk) disable iff (i_rst)
        (ck_wr || stop_enter) && !sc_wr |=> !cont_run_ff)
        else $error("continuous mode not stopped");

    a_halt_holds:
    assert property (@(posedge i_clk) disable iff (i_rst)
        state_ff == adcc_pkg::ADCC_ST_HALT && !sc_wr
        |=> state_ff == adcc_pkg::ADCC_ST_HALT && !start_ff)
        else $error("halted converter resumed without a write");

    a_single_once:
    assert property (@(posedge i_clk) disable iff (i_rst)
        eoc_ok && !cont_run_ff && !sc_wr |=> !converting && !start_ff)
        else $error("single conversion repeated");

    a_stop_aborts:
    assert property (@(posedge i_clk) disable iff (i_rst)
        stop_enter && converting && !sc_wr && !eoc_ok
        |=> abort_ff && !o_conv_cmd.powered)
        else $error("stop did not abort the conversion");

endmodule : adcc_top

/* tb/adcc_top_tb.sv */
// self-checking bench of the converter control with a reference model
`timescale 1ns/1ps
module adcc_top_tb;
    localparam logic [4:0] A_SC = 5'h00;
    localparam logic [4:0] A_RH = 5'h04;
    localparam logic [4:0] A_RL = 5'h08;
    localparam logic [4:0] A_CK = 5'h0C;
    localparam logic [4:0] A_EV = 5'h10;
    localparam logic [4:0] A_MK = 5'h14;
    logic                     i_clk;
    logic                     i_rst;
    logic [4:0]               i_avs_address;
    logic                     i_avs_read;
    logic                     i_avs_write;
    logic [31:0]              i_avs_writedata;
    logic [3:0]               i_avs_byteenable;
    logic [31:0]              o_avs_readdata;
    logic                     o_avs_waitrequest;
    logic                     i_conv_eoc;
    logic [9:0]               i_conv_data;
    adcc_pkg::adcc_conv_cmd_t o_conv_cmd;
    logic                     i_stop_mode;
    logic                     o_conv_irq;
    logic                     o_irq;
    int                       n_fail;
    int                       num_checks;
    int                       n_start;
    int                       n_abort;
    int                       cycles;
    logic [15:0]              lfsr;
    logic [31:0]              rd;
    // reference model state
    logic [6:0]               m_ctrl;
    logic                     m_done;
    logic                     m_cirq;
    logic                     m_run;
    logic                     m_cont;
    logic [9:0]               m_res;
    logic [1:0]               m_ck;
    logic [2:0]               m_evt;
    logic [2:0]               m_mask;
    logic [4:0]               codes [9];

    adcc_top #(.RES_W(10)) dut_u (
        .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata),
        .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
        .o_avs_waitrequest(o_avs_waitrequest), .i_conv_eoc(i_conv_eoc),
        .i_conv_data(i_conv_data), .o_conv_cmd(o_conv_cmd),
        .i_stop_mode(i_stop_mode), .o_conv_irq(o_conv_irq), .o_irq(o_irq));

    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // pulses counted at the edge that samples them; ceiling cuts a hang
    always @(posedge i_clk) begin
        if (o_conv_cmd.start === 1'b1) n_start++;
        if (o_conv_cmd.abort === 1'b1) n_abort++;
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [4:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= {24'h0, d};
        i_avs_byteenable <= be;
        i_avs_write <= wr;
        i_avs_read <= ~wr;
        do @(posedge i_clk); while (o_avs_waitrequest !== 1'b0);
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
    endtask : bus

    task automatic outs();
        #1;
        chk(o_conv_irq, m_cirq);
        chk(o_irq, |(m_evt & m_mask));
        chk(o_conv_cmd.powered, m_run);
        chk(o_conv_cmd.isolate, m_ctrl[4:0] == 5'h1F);
        chk(o_conv_cmd.channel, m_ctrl[4:0]);
        chk(o_conv_cmd.long_sample, m_ck[0]);
    endtask : outs

    task automatic wr(input logic [4:0] a, input logic [7:0] d,
                      input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (be[0] && a == A_MK) m_mask = d[2:0];
        if (be[0] && a == A_CK) begin
            m_ck = d[1:0];
            m_cont = 1'b0;
        end
        outs();
    endtask : wr

    task automatic wr_sc(input logic [7:0] d);
        int s0;
        int a0;
        logic was_run;
        s0 = n_start;
        a0 = n_abort;
        bus(1'b1, A_SC, d, 4'h1);
        // abort pulse follows the write edge, so count it afterwards
        was_run = m_run;
        if (m_run) m_evt[1] = 1'b1;
        m_ctrl = d[6:0];
        m_done = 1'b0;
        m_cirq = 1'b0;
        m_run = d[4:0] != 5'h1F;
        m_cont = d[5] & m_run;
        repeat (3) @(posedge i_clk);
        chk(n_abort - a0, was_run);
        chk(n_start - s0, m_run);
        outs();
    endtask : wr_sc

    task automatic eoc(input logic [9:0] v);
        int s0;
        s0 = n_start;
        @(posedge i_clk);
        i_conv_eoc <= 1'b1;
        i_conv_data <= v;
        @(posedge i_clk);
        i_conv_eoc <= 1'b0;
        i_conv_data <= ~v;
        if (m_run) begin
            m_done = 1'b1;
            m_res = v;
            m_evt[0] = 1'b1;
            m_cirq = m_cirq | m_ctrl[6];
            m_run = m_cont;
        end
        repeat (2) @(posedge i_clk);
        chk(n_start - s0, m_run);
        outs();
    endtask : eoc

    task automatic rd_chk(input logic [4:0] a);
        logic [31:0] e;
        case (a)
            A_SC: e = {24'h0, m_done, m_ctrl};
            A_RH: e = {30'h0, m_res[9:8]};
            A_RL: e = {24'h0, m_res[7:0]};
            A_CK: e = {30'h0, m_ck};
            A_EV: e = {29'h0, m_evt};
            A_MK: e = {29'h0, m_mask};
            default: e = 32'h0;
        endcase
        bus(1'b0, a, 8'h00, 4'hF);
        chk(rd, e);
        if (a == A_RL) m_done = 1'b0;
        if (a == A_RL || a == A_RH) m_cirq = 1'b0;
        if (a == A_EV) m_evt = 3'h0;
        outs();
    endtask : rd_chk

    initial begin
        int s0;
        int a0;
        i_rst = 1'b1;
        i_avs_address = 5'h00;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'h0;
        i_conv_eoc = 1'b0;
        i_conv_data = 10'h000;
        i_stop_mode = 1'b0;
        {n_fail, num_checks, n_start, n_abort, cycles} = '0;
        lfsr = 16'hE7B6;
        m_ctrl = 7'h1F;
        {m_done, m_cirq, m_run, m_cont} = 4'h0;
        m_res = 10'h000;
        m_ck = 2'h0;
        m_evt = 3'h0;
        m_mask = 3'h0;
        // bandgap code relies on the inhibit circuit kept powered
        codes = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1A, 5'h1D,
                  5'h1E};
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        rd_chk(A_SC);
        rd_chk(A_CK);
        rd_chk(5'h18);
        wr(A_MK, 8'h07, 4'h1);
        wr(A_MK, 8'h00, 4'h0);
        rd_chk(A_MK);
        // every selectable input, random result and interrupt enable
        foreach (codes[i]) begin
            lfsr = lfsr_next(lfsr);
            wr_sc({1'b0, lfsr[0], 1'b0, codes[i]});
            eoc(lfsr[15:6]);
            rd_chk(A_SC);
            rd_chk(A_RH);
            rd_chk(A_EV);
            rd_chk(A_RL);
            rd_chk(A_SC);
        end
        // masked events stay quiet; a write clears the flag, bit 7 ignored
        wr(A_MK, 8'h00, 4'h1);
        wr_sc(8'h42);
        eoc(10'h2A5);
        wr_sc(8'hC2);
        rd_chk(A_SC);
        rd_chk(A_EV);
        wr(A_MK, 8'h07, 4'h1);
        // back to back conversions, restart and channel-off ending
        wr_sc(8'h61);
        repeat (3) begin
            lfsr = lfsr_next(lfsr);
            eoc(lfsr[9:0]);
        end
        wr_sc(8'h62);
        eoc(10'h3FF);
        wr_sc(8'h3F);
        eoc(10'h155);
        rd_chk(A_SC);
        rd_chk(A_EV);
        // clock config write lets the current conversion end, then stops
        wr_sc(8'h23);
        wr(A_CK, 8'h01, 4'h1);
        eoc(10'h0F0);
        rd_chk(A_RL);
        // stop without the async clock halts until the next control write
        wr(A_CK, 8'h00, 4'h1);
        wr_sc(8'h24);
        s0 = n_start;
        a0 = n_abort;
        @(posedge i_clk);
        i_stop_mode <= 1'b1;
        repeat (3) @(posedge i_clk);
        chk(n_abort - a0, 1);
        m_run = 1'b0;
        m_cont = 1'b0;
        m_evt[1] = 1'b1;
        m_evt[2] = 1'b1;
        outs();
        bus(1'b0, A_EV, 8'h00, 4'hF);
        chk(rd, {29'h0, m_evt});
        m_evt = 3'h0;
        eoc(10'h111);
        @(posedge i_clk);
        i_stop_mode <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk(n_start - s0, 0);
        wr_sc(8'h24);
        eoc(10'h222);
        rd_chk(A_RL);
        tally_and_finish();
    end
endmodule : adcc_top_tb
